// [rtl/edor_cfg.svh]
// Register indices, reset values, field positions and limits of the
// exposure and dark offset register bank.
// Assumes it is included by the package and by the bank module.
`ifndef EDOR_CFG_SVH
`define EDOR_CFG_SVH

`define EDOR_IDX_FINE_HI      8'h20
`define EDOR_IDX_FINE_LO      8'h21
`define EDOR_IDX_COARSE_HI    8'h22
`define EDOR_IDX_COARSE_LO    8'h23
`define EDOR_IDX_GAIN         8'h24
`define EDOR_IDX_CLKDIV       8'h25
`define EDOR_IDX_DOFS_HI      8'h3C
`define EDOR_IDX_DOFS_LO      8'h3D
`define EDOR_IDX_DSETUP       8'h3E

`define EDOR_RST_FINE         9'h000
`define EDOR_RST_COARSE       9'h12E
`define EDOR_RST_GAIN         8'hF0
`define EDOR_RST_CLKDIV       4'h0
`define EDOR_RST_DOFS         11'h000
`define EDOR_RST_DMODE        2'h1
`define EDOR_RST_DHALF        1'b0
`define EDOR_RST_DNARROW      1'b1

`define EDOR_DS_MODE_LSB      0
`define EDOR_DS_HALF_BIT      2
`define EDOR_DS_NARROW_BIT    6
`define EDOR_DS_EXT_BIT       1
`define EDOR_DS_APPLY_BIT     0

`define EDOR_FINE_MARGIN_NTSC 10'h033
`define EDOR_FINE_MARGIN_PAL  10'h056
`define EDOR_FINE_MARGIN_CIF  10'h033
`define EDOR_FINE_MARGIN_QCIF 10'h017

`define EDOR_COARSE_CAP_NTSC  9'h104
`define EDOR_COARSE_CAP_PAL   9'h136
`define EDOR_COARSE_CAP_CIF   9'h13E
`define EDOR_COARSE_CAP_QCIF  9'h09E
`define EDOR_COARSE_MARGIN    10'h001

`define EDOR_DB_WIDE          12'h004
`define EDOR_DB_NARROW        12'h002
`define EDOR_AVG_SHIFT        4

`endif

// [rtl/edor_pkg.sv]
// Types shared by the exposure and dark offset register bank.
// Assumes edor_cfg.svh is on the include path.
`include "edor_cfg.svh"

package edor_pkg;

    typedef enum logic [1:0] {
        EDOR_NTSC,
        EDOR_PAL,
        EDOR_CIF,
        EDOR_QCIF
    } edor_mode_t;

    typedef struct packed {
        logic       vld;
        logic       dark;
        logic [9:0] data;
    } edor_pix_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } edor_acc_t;

endpackage : edor_pkg

// [rtl/edor_regs.sv]
// Exposure and dark offset register bank with deferred update, clipping,
// gain DAC drive, pixel clock tick and dark level cancellation.
// Assumes an index-addressed serial slave in front and video timing on clk.
//
// Operation
// RULE1: exposure settings applied only at field sync
// RULE2: over-range values clipped to current maximum
// RULE3: fine limit from line, coarse from field
// RULE4: fine exposure nine bits, index 32/33
// RULE5: fine limit line minus 51/86/51/23
// RULE6: coarse nine bits, index 34/35, reset 302
// RULE7: coarse caps 260/310/318/158 standard modes
// RULE8: gain high nibble capacitor, low current
// RULE9: host keeps current gain nibble below 13
// RULE10: pixel clock divided by setting plus one
// RULE11: dark offset eleven-bit signed, index 44/45; the bank decodes 60/61
// RULE12: host sets mode 1x for external offset; the bank applies it only in mode 11, mode 10 applies none
// RULE13: always average dark; mode picks offset
// RULE14: half mode uses dark lines after dark
// RULE15: integrator holds inside deadband, bit six
// RULE16: current DAC is inverted low gain nibble; the bank also bit-reverses it when retro_gain is set
// RULE17: reserved bits and indices read zero
`timescale 1ns/1ps
`default_nettype none
`include "edor_cfg.svh"

module edor_regs
    import edor_pkg::*;
#(
    parameter logic [9:0] DARK_TARGET = 10'h040
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire edor_acc_t  acc,
    output logic [7:0]      rdata,
    input  wire edor_mode_t video_mode,
    input  wire logic       std_mode,
    input  wire logic [9:0] line_length,
    input  wire logic [9:0] field_length,
    input  wire logic       field_sync,
    input  wire logic       retro_gain,
    input  wire logic       line_start,
    input  wire edor_pix_t  pix_in,
    output logic [8:0]      fine_exposure,
    output logic [8:0]      coarse_exposure,
    output logic [3:0]      capacitor_gain_dac,
    output logic [3:0]      current_gain_dac,
    output logic            pix_clk_tick,
    output logic [9:0]      dark_average,
    output logic [10:0]     dark_integrator,
    output edor_pix_t       pix_out
);

    // A target this close to full scale leaves no room above the deadband.
    if (DARK_TARGET > 10'h3FB) begin : g_target_chk
        $error("DARK_TARGET out of range");
    end

    // Programmed values as the host sees them.
    logic [8:0]  fine_r;
    logic [8:0]  coarse_r;
    logic [7:0]  gain_r;
    logic [3:0]  clkdiv_r;
    logic [10:0] dofs_r;
    logic [1:0]  dmode_r;
    logic        dhalf_r;
    logic        dnarrow_r;

    // Values in force, refreshed at field sync, and the pixel clock divider count.
    logic [7:0]  gain_act_r;
    logic [3:0]  clkdiv_act_r;
    logic [3:0]  clkcnt_r;

    logic [9:0]  fine_margin;
    logic [9:0]  fine_max;
    logic [9:0]  coarse_max;
    logic [7:0]  rdata_nxt;
    logic [3:0]  current_gain_dac_inv;
    logic [3:0]  current_gain_dac_rev;

    // RULE4 fine exposure storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_r <= `EDOR_RST_FINE;
        end else if (acc.wr && acc.idx == `EDOR_IDX_FINE_HI) begin
            fine_r[8] <= acc.wdata[0];
        end else if (acc.wr && acc.idx == `EDOR_IDX_FINE_LO) begin
            fine_r[7:0] <= acc.wdata;
        end
    end

    // RULE6 coarse exposure storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coarse_r <= `EDOR_RST_COARSE;
        end else if (acc.wr && acc.idx == `EDOR_IDX_COARSE_HI) begin
            coarse_r[8] <= acc.wdata[0];
        end else if (acc.wr && acc.idx == `EDOR_IDX_COARSE_LO) begin
            coarse_r[7:0] <= acc.wdata;
        end
    end

    // RULE8 gain storage; the capacitor nibble is locked in retro mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_r <= `EDOR_RST_GAIN;
        end else if (acc.wr && acc.idx == `EDOR_IDX_GAIN) begin
            gain_r[3:0] <= acc.wdata[3:0];
            if (!retro_gain) begin
                gain_r[7:4] <= acc.wdata[7:4];
            end
        end
    end

    // RULE10 divisor setting storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkdiv_r <= `EDOR_RST_CLKDIV;
        end else if (acc.wr && acc.idx == `EDOR_IDX_CLKDIV) begin
            clkdiv_r <= acc.wdata[3:0];
        end
    end

    // RULE11 signed dark offset storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dofs_r <= `EDOR_RST_DOFS;
        end else if (acc.wr && acc.idx == `EDOR_IDX_DOFS_HI) begin
            dofs_r[10:8] <= acc.wdata[2:0];
        end else if (acc.wr && acc.idx == `EDOR_IDX_DOFS_LO) begin
            dofs_r[7:0] <= acc.wdata;
        end
    end

    // RULE13 dark setup fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmode_r   <= `EDOR_RST_DMODE;
            dhalf_r   <= `EDOR_RST_DHALF;
            dnarrow_r <= `EDOR_RST_DNARROW;
        end else if (acc.wr && acc.idx == `EDOR_IDX_DSETUP) begin
            dmode_r   <= acc.wdata[`EDOR_DS_MODE_LSB +: 2];
            dhalf_r   <= acc.wdata[`EDOR_DS_HALF_BIT];
            dnarrow_r <= acc.wdata[`EDOR_DS_NARROW_BIT];
        end
    end

    // RULE17 unused bits and indices read zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (acc.idx)
            `EDOR_IDX_FINE_HI:   rdata_nxt = {7'h00, fine_r[8]};
            `EDOR_IDX_FINE_LO:   rdata_nxt = fine_r[7:0];
            `EDOR_IDX_COARSE_HI: rdata_nxt = {7'h00, coarse_r[8]};
            `EDOR_IDX_COARSE_LO: rdata_nxt = coarse_r[7:0];
            `EDOR_IDX_GAIN:      rdata_nxt = gain_r;
            `EDOR_IDX_CLKDIV:    rdata_nxt = {4'h0, clkdiv_r};
            `EDOR_IDX_DOFS_HI:   rdata_nxt = {5'h00, dofs_r[10:8]};
            `EDOR_IDX_DOFS_LO:   rdata_nxt = dofs_r[7:0];
            `EDOR_IDX_DSETUP:    rdata_nxt = {1'b0, dnarrow_r, 3'h0, dhalf_r, dmode_r};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    // Read data stays put until the next read strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (acc.rd) begin
            rdata <= rdata_nxt;
        end
    end

    // RULE5 fine margin per video mode
    always_comb begin
        case (video_mode)
            EDOR_NTSC: fine_margin = `EDOR_FINE_MARGIN_NTSC;
            EDOR_PAL:  fine_margin = `EDOR_FINE_MARGIN_PAL;
            EDOR_CIF:  fine_margin = `EDOR_FINE_MARGIN_CIF;
            EDOR_QCIF: fine_margin = `EDOR_FINE_MARGIN_QCIF;
            default:   fine_margin = `EDOR_FINE_MARGIN_NTSC;
        endcase
    end

    // RULE3 ceilings follow current line and field length
    always_comb begin
        fine_max = (line_length > fine_margin) ? line_length - fine_margin : 10'h000;
        if (field_length > `EDOR_COARSE_MARGIN) begin
            coarse_max = field_length - `EDOR_COARSE_MARGIN;
        end else begin
            coarse_max = 10'h000;
        end
        // RULE7 standard mode coarse caps
        if (std_mode) begin
            case (video_mode)
                EDOR_NTSC: coarse_max = {1'b0, `EDOR_COARSE_CAP_NTSC};
                EDOR_PAL:  coarse_max = {1'b0, `EDOR_COARSE_CAP_PAL};
                EDOR_CIF:  coarse_max = {1'b0, `EDOR_COARSE_CAP_CIF};
                EDOR_QCIF: coarse_max = {1'b0, `EDOR_COARSE_CAP_QCIF};
                default:   coarse_max = {1'b0, `EDOR_COARSE_CAP_NTSC};
            endcase
        end
    end

    // RULE1 exposure updated only at field sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_exposure   <= `EDOR_RST_FINE;
            coarse_exposure <= `EDOR_RST_COARSE;
            gain_act_r      <= `EDOR_RST_GAIN;
            clkdiv_act_r    <= `EDOR_RST_CLKDIV;
        end else if (field_sync) begin
            // RULE2 clip to current maximum
            fine_exposure   <= ({1'b0, fine_r} > fine_max) ? fine_max[8:0] : fine_r;
            coarse_exposure <= ({1'b0, coarse_r} > coarse_max) ? coarse_max[8:0] : coarse_r;
            gain_act_r      <= gain_r;
            clkdiv_act_r    <= clkdiv_r;
        end
    end

    assign current_gain_dac_inv = ~gain_act_r[3:0];

    // Bit reversal of the inverted nibble for the retro drive.
    for (genvar b = 0; b < 4; b++) begin : g_current_gain_dac_rev
        assign current_gain_dac_rev[b] = current_gain_dac_inv[3 - b];
    end

    // RULE16 current DAC inverted, reversed in retro
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capacitor_gain_dac <= 4'h0;
            current_gain_dac   <= 4'h0;
        end else begin
            capacitor_gain_dac <= gain_act_r[7:4];
            current_gain_dac   <= retro_gain ? current_gain_dac_rev : current_gain_dac_inv;
        end
    end

    // RULE10 tick every setting plus one cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkcnt_r     <= 4'h0;
            pix_clk_tick <= 1'b0;
        end else if (clkcnt_r >= clkdiv_act_r) begin
            clkcnt_r     <= 4'h0;
            pix_clk_tick <= 1'b1;
        end else begin
            clkcnt_r     <= clkcnt_r + 4'h1;
            pix_clk_tick <= 1'b0;
        end
    end

    // Dark level tracking.
    logic        cur_line_dark_r;
    logic        prev_line_dark_r;
    logic        dark_use;
    logic [13:0] avg_acc_r;
    logic [14:0] avg_sum;
    logic [11:0] avg_err;
    logic [11:0] deadband;
    logic [11:0] pix_sum;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_line_dark_r  <= 1'b0;
            prev_line_dark_r <= 1'b0;
        end else if (line_start) begin
            // A dark pixel in the start cycle already belongs to the new line.
            prev_line_dark_r <= cur_line_dark_r;
            cur_line_dark_r  <= pix_in.vld && pix_in.dark;
        end else if (pix_in.vld && pix_in.dark) begin
            cur_line_dark_r <= 1'b1;
        end
    end

    // RULE14 half mode skips first dark line
    assign dark_use = pix_in.vld && pix_in.dark && (!dhalf_r || prev_line_dark_r);

    // RULE13 dark average kept in every mode
    assign avg_sum = {1'b0, avg_acc_r} + {5'h00, pix_in.data}
                   - {5'h00, avg_acc_r[13:`EDOR_AVG_SHIFT]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avg_acc_r <= 14'h0000;
        end else if (dark_use) begin
            avg_acc_r <= avg_sum[13:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dark_average <= 10'h000;
        end else begin
            dark_average <= avg_acc_r[13:`EDOR_AVG_SHIFT];
        end
    end

    assign avg_err  = {2'b00, dark_average} - {2'b00, DARK_TARGET};
    assign deadband = dnarrow_r ? `EDOR_DB_NARROW : `EDOR_DB_WIDE;

    // RULE15 saturating up/down integrator holds in deadband
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dark_integrator <= 11'h000;
        end else if (field_sync) begin
            // Steps stop at the signed limits rather than wrapping.
            if ($signed(avg_err) > $signed(deadband) && dark_integrator != 11'h3FF) begin
                dark_integrator <= dark_integrator + 11'h001;
            end else if ($signed(avg_err) < -$signed(deadband)
                         && dark_integrator != 11'h400) begin
                dark_integrator <= dark_integrator - 11'h001;
            end
        end
    end

    // RULE13 mode selects applied offset
    always_comb begin
        if (!dmode_r[`EDOR_DS_APPLY_BIT]) begin
            pix_sum = {2'b00, pix_in.data};
        end else if (dmode_r[`EDOR_DS_EXT_BIT]) begin
            pix_sum = {2'b00, pix_in.data} - {dofs_r[10], dofs_r};
        end else begin
            pix_sum = {2'b00, pix_in.data} - {dark_integrator[10], dark_integrator};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_out <= '0;
        end else begin
            pix_out.vld  <= pix_in.vld;
            pix_out.dark <= pix_in.dark;
            // Negative results clamp to zero, overflow to full scale.
            if (pix_sum[11]) begin
                pix_out.data <= 10'h000;
            end else if (pix_sum[10]) begin
                pix_out.data <= 10'h3FF;
            end else begin
                pix_out.data <= pix_sum[9:0];
            end
        end
    end

endmodule : edor_regs
`default_nettype wire

// [verification/edor_regs_sva.sv]
// Checker for the exposure and dark offset register bank.
// Assumes it is bound onto every edor_regs instance.
`timescale 1ns/1ps
`default_nettype none
module edor_regs_sva
    import edor_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire edor_acc_t   acc,
    input wire logic [7:0]  rdata,
    input wire edor_mode_t  video_mode,
    input wire logic        std_mode,
    input wire logic [9:0]  line_length,
    input wire logic [9:0]  field_length,
    input wire logic        field_sync,
    input wire edor_pix_t   pix_in,
    input wire logic [8:0]  fine_exposure,
    input wire logic [8:0]  coarse_exposure,
    input wire logic [10:0] dark_integrator,
    input wire edor_pix_t   pix_out
);
    logic [9:0] marg;
    logic [9:0] cap;
    logic [9:0] fmax;
    logic [9:0] cmax;
    always_comb begin
        case (video_mode)
            EDOR_NTSC: begin marg = 10'h033; cap = 10'h104; end
            EDOR_PAL:  begin marg = 10'h056; cap = 10'h136; end
            EDOR_CIF:  begin marg = 10'h033; cap = 10'h13E; end
            default:   begin marg = 10'h017; cap = 10'h09E; end
        endcase
        fmax = (line_length > marg) ? line_length - marg : 10'h000;
        cmax = std_mode ? cap : field_length - 10'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    exp_hold_a: assert property (
        !field_sync |=> $stable(fine_exposure) && $stable(coarse_exposure))
        else $error("exposure moved without field sync");
    fine_clip_a: assert property (
        field_sync |=> fine_exposure <= $past(fmax)) else $error("fine above limit");
    coarse_clip_a: assert property (
        field_sync |=> coarse_exposure <= $past(cmax)) else $error("coarse above limit");
    integ_hold_a: assert property (
        !field_sync |=> $stable(dark_integrator)) else $error("integrator moved");
    integ_step_a: assert property (
        field_sync |=> (dark_integrator - $past(dark_integrator)) inside
        {11'h000, 11'h001, 11'h7FF}) else $error("integrator step too large");
    unmapped_rd_a: assert property (
        acc.rd && acc.idx == 8'h30 |=> rdata == 8'h00) else $error("unmapped read");
    fine_store_a: assert property (
        acc.wr && acc.idx == 8'h21 ##2 acc.rd && acc.idx == 8'h21
        |=> rdata == $past(acc.wdata, 3)) else $error("fine low byte lost");
    pix_pass_a: assert property (
        pix_in.vld |=> pix_out.vld) else $error("pixel dropped");
endmodule : edor_regs_sva
bind edor_regs edor_regs_sva chk (
    .clk(clk), .rst_n(rst_n), .acc(acc), .rdata(rdata), .video_mode(video_mode),
    .std_mode(std_mode), .line_length(line_length), .field_length(field_length),
    .field_sync(field_sync), .pix_in(pix_in), .fine_exposure(fine_exposure),
    .coarse_exposure(coarse_exposure), .dark_integrator(dark_integrator),
    .pix_out(pix_out)
);
`default_nettype wire

// [verification/edor_host.sv]
// Host model acting as the register bus master of the bank.
// Assumes clk is the bank clock and calls start just after an edge.
`timescale 1ns/1ps
`default_nettype none
module edor_host
    import edor_pkg::*;
(
    input wire logic       clk,
    output var edor_acc_t  acc,
    input wire logic [7:0] rdata
);
    initial acc = '0;
    // One access held through one edge; released lines show inverted values.
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        #1 acc = '{wr: w, rd: !w, idx: i, wdata: d};
        @(posedge clk);
        #1 q = rdata;
        acc = '{wr: 1'b0, rd: 1'b0, idx: ~i, wdata: ~d};
    endtask : xfer
endmodule : edor_host
`default_nettype wire

// [verification/edor_regs_tb_top.sv]
// Self-checking bench for the exposure and dark offset register bank.
// Assumes edor_host as bus master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module edor_regs_tb_top
    import edor_pkg::*;
;
    logic        clk, rst_n, field_sync, retro_gain, line_start, std_mode, pix_clk_tick;
    logic [9:0]  line_length, field_length, dark_average;
    edor_mode_t  video_mode;
    edor_pix_t   pix_in, pix_out;
    edor_acc_t   acc;
    logic [7:0]  rdata, q;
    logic [8:0]  fine_exposure, coarse_exposure;
    logic [3:0]  capacitor_gain_dac, current_gain_dac;
    logic [10:0] dark_integrator;
    int          failures, checks_done, n;
    logic [31:0] rows [11];
    logic [9:0]  pxe [3];
    logic [8:0]  fe [4];
    logic [8:0]  ce [4];
    edor_regs dut (
        .clk(clk), .rst_n(rst_n), .acc(acc), .rdata(rdata), .video_mode(video_mode),
        .std_mode(std_mode), .line_length(line_length), .field_length(field_length),
        .field_sync(field_sync), .retro_gain(retro_gain), .line_start(line_start),
        .pix_in(pix_in), .fine_exposure(fine_exposure), .coarse_exposure(coarse_exposure),
        .capacitor_gain_dac(capacitor_gain_dac), .current_gain_dac(current_gain_dac),
        .pix_clk_tick(pix_clk_tick), .dark_average(dark_average),
        .dark_integrator(dark_integrator), .pix_out(pix_out)
    );
    edor_host host (.clk(clk), .acc(acc), .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic sync();
        field_sync = 1'b1;
        @(posedge clk);
        #1 field_sync = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : sync
    task automatic pix(input logic [9:0] d);
        @(posedge clk);
        #1 pix_in = '{vld: 1'b1, dark: 1'b0, data: d};
        @(posedge clk);
        #1 pix_in = '{vld: 1'b0, dark: 1'b0, data: ~d};
    endtask : pix
    task automatic gap();
        n = 0;
        do begin @(posedge clk); #1; n++; end while (pix_clk_tick !== 1'b1 && n < 40);
        n = 0;
        do begin @(posedge clk); #1; n++; end while (pix_clk_tick !== 1'b1 && n < 40);
    endtask : gap
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {rst_n, field_sync, retro_gain, line_start, pix_in} = '0;
        {std_mode, line_length, field_length} = {1'b1, 10'd600, 10'd400};
        video_mode = EDOR_NTSC;
        // Index, reset value, write data, readback.
        rows = '{32'h2000FF01, 32'h2100A5A5, 32'h2201FF01, 32'h232E3C3C, 32'h24F07A7A,
                 32'h2500FF0F, 32'h3C00FF07, 32'h3D008080, 32'h3E41FF47, 32'h3000FF00,
                 32'h3F00FF00};
        pxe = '{10'h0E4, 10'h063, 10'h064};
        fe = '{9'd149, 9'd114, 9'd149, 9'd177};
        ce = '{9'd260, 9'd310, 9'd318, 9'd158};
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (rows[k]) begin
            host.xfer(1'b0, rows[k][31:24], 8'h00, q);
            chk("reset value", rows[k][23:16], q);
            host.xfer(1'b1, rows[k][31:24], rows[k][15:8], q);
            host.xfer(1'b0, rows[k][31:24], 8'h00, q);
            chk("readback", rows[k][7:0], q);
        end
        gap();
        chk("tick gap div1", 16'd1, n);
        $display("test registers done");
        host.xfer(1'b1, 8'h3E, 8'h00, q);
        pix_in = '{vld: 1'b1, dark: 1'b1, data: 10'h043};
        repeat (300) @(posedge clk);
        #1 pix_in = '{vld: 1'b0, dark: 1'b0, data: 10'h3BC};
        chk("dark average", 16'h043, dark_average);
        sync();
        chk("integrator wide", 16'h000, dark_integrator);
        host.xfer(1'b1, 8'h3E, 8'h40, q);
        sync();
        chk("integrator narrow", 16'h001, dark_integrator);
        chk("cap dac", 16'h7, capacitor_gain_dac);
        chk("current dac", 16'h5, current_gain_dac);
        gap();
        chk("tick gap div16", 16'd16, n);
        $display("test dark done");
        foreach (pxe[k]) begin
            host.xfer(1'b1, 8'h3E, (k == 0) ? 8'h03 : (k == 1) ? 8'h41 : 8'h00, q);
            pix(10'd100);
            chk("pixel out", pxe[k], pix_out.data);
        end
        host.xfer(1'b1, 8'h3E, 8'h03, q);
        pix(10'h3E8);
        chk("pixel saturate", 16'h3FF, pix_out.data);
        chk("pixel flags", 16'h2, {pix_out.vld, pix_out.dark});
        $display("test pixel done");
        host.xfer(1'b1, 8'h3E, 8'h04, q);
        pix_in = '{vld: 1'b1, dark: 1'b1, data: 10'h010};
        repeat (40) @(posedge clk);
        #1 chk("half first line", 16'h043, dark_average);
        line_start = 1'b1;
        @(posedge clk);
        #1 line_start = 1'b0;
        repeat (300) @(posedge clk);
        #1 pix_in = '{vld: 1'b0, dark: 1'b0, data: 10'h3EF};
        chk("half second line", 16'h010, dark_average);
        $display("test half mode done");
        host.xfer(1'b1, 8'h20, 8'h01, q);
        host.xfer(1'b1, 8'h21, 8'h2C, q);
        host.xfer(1'b1, 8'h23, 8'hFF, q);
        chk("fine held", 16'h1A5, fine_exposure);
        line_length = 10'd200;
        foreach (fe[k]) begin
            video_mode = edor_mode_t'(k);
            sync();
            chk("fine clip", fe[k], fine_exposure);
            chk("coarse cap", ce[k], coarse_exposure);
        end
        {std_mode, field_length} = {1'b0, 10'd300};
        sync();
        chk("coarse field", 16'd299, coarse_exposure);
        $display("test exposure done");
        retro_gain = 1'b1;
        host.xfer(1'b1, 8'h24, 8'h2B, q);
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk("gain retro", 16'h7B, q);
        sync();
        chk("retro current dac", 16'h2, current_gain_dac);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk("gain after reset", 16'hF0, q);
        chk("fine reset", 16'h000, fine_exposure);
        chk("coarse reset", 16'h12E, coarse_exposure);
        $display("test retro and reset done");
        tally_and_finish();
    end
endmodule : edor_regs_tb_top
`default_nettype wire
